// ==== design/cam_top.sv ====
// counter array: shared 16-bit counter, control/flags and five modules
//
// Notes on behaviour
// - mode register bits six..zero; bit seven reserved
// - any capture enable selects capture mode
// - capture on rising, falling or either edge
// - pin sampled each counter tick
// - capture copies counter into capture bytes
// - capture flag plus enable requests interrupt
// - compare plus match flag gives software timer
// - timer match with flag and enable interrupts
// - toggle output needs toggle, match, compare
// - toggle output inverts pin on each match
// - pwm needs pulse width and compare enables
// - pwm low below duty byte, else high
// - low byte rollover reloads duty from high
// - every module has its own duty
// - all pwm share one counter frequency
// - toggle on match toggles pin at match
// - event flags set by hardware, software clears
// - module four watchdog match gives internal reset
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module cam_top
    import cam_pkg::*;
(
    input  wire logic                CLOCK,
    input  wire logic                RST_N,
    input  wire logic                COUNT_TICK,
    input  wire logic [3:0]          ADDR,
    input  wire logic                ADDR_HI,
    input  wire logic [7:0]          WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    output logic      [7:0]          RDATA,
    input  wire logic [CAM_NMOD-1:0] PIN_IN,
    output logic      [CAM_NMOD-1:0] PIN_OUT,
    output logic      [CAM_NMOD-1:0] PIN_OE_N,
    output logic                     IRQ,
    output logic                     WDOG_RESET
);
    logic [7:0]          mode_r [CAM_NMOD];
    logic [CAM_NMOD-1:0] flag_r;
    logic                run_r;
    logic                wdog_r;
    logic [15:0]         cnt_r;
    logic [7:0]          rdata_r;
    logic                wdog_rst_r;
    logic [CAM_NMOD-1:0] ev_set;
    logic [CAM_NMOD-1:0] mat;
    logic [CAM_NMOD-1:0] drive;
    logic [7:0]          cap_lo [CAM_NMOD];
    logic [7:0]          cap_hi [CAM_NMOD];
    logic                tick;
    logic [4:0]          full_addr;

    // counter only advances while run is set and the tick enable fires
    assign tick      = COUNT_TICK & run_r;
    assign full_addr = {ADDR_HI, ADDR};

    // index of a register inside a bank of per-module registers
    function automatic logic [4:0] cam_index(input logic [4:0] a, input logic [4:0] base);
        cam_index = a - base;
    endfunction : cam_index

    // shared counter, also writable by software
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_r <= 16'h0000;
        end else if (WR && full_addr == {1'b0, CAM_ADDR_CNTL}) begin
            cnt_r[7:0] <= WDATA;
        end else if (WR && full_addr == {1'b0, CAM_ADDR_CNTH}) begin
            cnt_r[15:8] <= WDATA;
        end else if (tick) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // run bit, watchdog enable and mode registers
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            run_r  <= 1'b0;
            wdog_r <= 1'b0;
            for (int i = 0; i < CAM_NMOD; i++) begin
                mode_r[i] <= CAM_MODE_RST;
            end
        end else if (WR) begin
            if (full_addr == {1'b0, CAM_ADDR_CTRL}) begin
                run_r <= WDATA[CAM_B_RUN];
            end
            if (full_addr == {1'b0, CAM_ADDR_WDOG}) begin
                wdog_r <= WDATA[0];
            end
            for (int i = 0; i < CAM_NMOD; i++) begin
                if (cam_index(full_addr, {1'b0, CAM_ADDR_MODE0}) == 5'(i)) begin
                    mode_r[i] <= WDATA & CAM_MODE_MSK;
                end
            end
        end
    end

    // event flags: hardware set beats a software clear in the same cycle
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            flag_r <= '0;
        end else begin
            if (WR && full_addr == {1'b0, CAM_ADDR_CTRL}) begin
                flag_r <= (flag_r & WDATA[CAM_NMOD-1:0]) | ev_set;
            end else begin
                flag_r <= flag_r | ev_set;
            end
        end
    end

    // one module per pin, all watching the same counter
    for (genvar g = 0; g < CAM_NMOD; g++) begin : g_mod
        cam_cfg_t cfg;
        assign cfg = '{mode: mode_r[g], cnt: cnt_r, tick: tick};
        cam_module u_mod (
            .clk       (CLOCK),
            .rst_n     (RST_N),
            .cfg       (cfg),
            .pin_in    (PIN_IN[g]),
            .wr_lo     (WR && cam_index(full_addr, {1'b0, CAM_ADDR_CAPL0}) == 5'(g)),
            .wr_hi     (WR && cam_index(full_addr, CAM_ADDR_CAPHB) == 5'(g)),
            .wdata     (WDATA),
            .cap_lo    (cap_lo[g]),
            .cap_hi    (cap_hi[g]),
            .pin_out   (PIN_OUT[g]),
            .pin_drive (drive[g]),
            .event_set (ev_set[g]),
            .match     (mat[g])
        );
        assign PIN_OE_N[g] = ~drive[g];
    end

    // interrupt whenever a set flag has its module enable
    always_comb begin
        IRQ = 1'b0;
        for (int i = 0; i < CAM_NMOD; i++) begin
            IRQ = IRQ | (flag_r[i] & mode_r[i][CAM_B_IRQE]);
        end
    end

    // internal reset pulse; no pin is driven by it
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            wdog_rst_r <= 1'b0;
        end else begin
            wdog_rst_r <= wdog_r & mat[CAM_WDOG_MOD];
        end
    end
    assign WDOG_RESET = wdog_rst_r;

    // read data, one cycle after the read strobe; unmapped reads zero
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_r <= CAM_ZERO8;
        end else if (RD) begin
            rdata_r <= CAM_ZERO8;
            if (full_addr == {1'b0, CAM_ADDR_CTRL}) begin
                rdata_r <= {1'b0, run_r, 1'b0, flag_r};
            end
            if (full_addr == {1'b0, CAM_ADDR_CNTL}) begin
                rdata_r <= cnt_r[7:0];
            end
            if (full_addr == {1'b0, CAM_ADDR_CNTH}) begin
                rdata_r <= cnt_r[15:8];
            end
            if (full_addr == {1'b0, CAM_ADDR_WDOG}) begin
                rdata_r <= {7'h00, wdog_r};
            end
            for (int i = 0; i < CAM_NMOD; i++) begin
                if (cam_index(full_addr, {1'b0, CAM_ADDR_MODE0}) == 5'(i)) begin
                    rdata_r <= mode_r[i];
                end
                if (cam_index(full_addr, {1'b0, CAM_ADDR_CAPL0}) == 5'(i)) begin
                    rdata_r <= cap_lo[i];
                end
                if (cam_index(full_addr, CAM_ADDR_CAPHB) == 5'(i)) begin
                    rdata_r <= cap_hi[i];
                end
            end
        end else begin
            rdata_r <= CAM_ZERO8;
        end
    end
    assign RDATA = rdata_r;
endmodule : cam_top

// ==== design/cam_pkg.sv ====
// package: register map, field positions and types for the counter array modules
package cam_pkg;
    localparam int        CAM_NMOD        = 5;
    localparam logic [3:0] CAM_ADDR_CTRL  = 4'h0;  // counter_control_reg
    localparam logic [3:0] CAM_ADDR_CNTL  = 4'h1;  // counter_low_byte
    localparam logic [3:0] CAM_ADDR_CNTH  = 4'h2;  // counter_high_byte
    localparam logic [3:0] CAM_ADDR_WDOG  = 4'h3;  // watchdog_enable control
    localparam logic [3:0] CAM_ADDR_MODE0 = 4'h4;  // module_mode_reg 0..4 at 4..8
    localparam logic [3:0] CAM_ADDR_CAPL0 = 4'h9;  // capture_low_byte 0..4 at 9..d
    localparam logic [3:0] CAM_ADDR_CAPH0 = 4'he;  // capture_high_byte: index e (+n) wraps
    localparam logic [4:0] CAM_ADDR_CAPHB = 5'h0e; // base of high bytes in 5-bit space
    localparam int        CAM_B_IRQE  = 0;
    localparam int        CAM_B_PWM   = 1;
    localparam int        CAM_B_TOG   = 2;
    localparam int        CAM_B_MAT   = 3;
    localparam int        CAM_B_FALL  = 4;
    localparam int        CAM_B_RISE  = 5;
    localparam int        CAM_B_CMP   = 6;
    localparam int        CAM_B_RUN   = 6;
    localparam logic [7:0] CAM_MODE_RST = 8'h00;
    localparam logic [7:0] CAM_MODE_MSK = 8'h7f;
    localparam logic [7:0] CAM_BYTE_MAX = 8'hff;
    localparam logic [7:0] CAM_ZERO8    = 8'h00;
    localparam int        CAM_WDOG_MOD = 4;

    // one module's configuration and counter view travel together
    typedef struct packed {
        logic [7:0]  mode;
        logic [15:0] cnt;
        logic        tick;
    } cam_cfg_t;
endpackage : cam_pkg

// ==== design/cam_edge.sv ====
// edge qualifier for one module pin, sampled once per counter tick
`timescale 1ns/10ps
module cam_edge
    import cam_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       tick,
    input  wire logic       pin,
    input  wire logic       rise_en,
    input  wire logic       fall_en,
    output logic            valid
);
    logic prev_r;

    // remember the level seen at the last counter tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
        end else if (tick) begin
            prev_r <= pin;
        end
    end

    // a change in an enabled direction is a valid transition
    assign valid = tick & ((rise_en & pin & ~prev_r)
                         | (fall_en & ~pin & prev_r));
endmodule : cam_edge

// ==== design/cam_module.sv ====
// one capture/compare module: capture, timer, toggle output and pwm
`timescale 1ns/10ps
module cam_module
    import cam_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  cam_cfg_t        cfg,
    input  wire logic       pin_in,
    input  wire logic       wr_lo,
    input  wire logic       wr_hi,
    input  wire logic [7:0] wdata,
    output logic [7:0]      cap_lo,
    output logic [7:0]      cap_hi,
    output logic            pin_out,
    output logic            pin_drive,
    output logic            event_set,
    output logic            match
);
    logic [7:0] lo_r;
    logic [7:0] hi_r;
    logic       tog_r;
    logic       pwm_r;
    logic       cap_mode;
    logic       pwm_mode;
    logic       cap_ev;

    assign cap_mode = cfg.mode[CAM_B_RISE] | cfg.mode[CAM_B_FALL];
    assign pwm_mode = cfg.mode[CAM_B_PWM] & cfg.mode[CAM_B_CMP];
    // compare each tick against the full 16-bit register
    assign match = cfg.tick & cfg.mode[CAM_B_CMP] & ~pwm_mode
                 & (cfg.cnt == {hi_r, lo_r});

    // the pin is tracked on every tick, not only in capture mode, so a module that
    // enters capture mode with its pin already high sees no false edge
    cam_edge u_edge (
        .clk     (clk),
        .rst_n   (rst_n),
        .tick    (cfg.tick),
        .pin     (pin_in),
        .rise_en (cfg.mode[CAM_B_RISE]),
        .fall_en (cfg.mode[CAM_B_FALL]),
        .valid   (cap_ev)
    );

    assign event_set = (cap_ev & cap_mode) | (match & cfg.mode[CAM_B_MAT]);

    // capture load, software write and pwm reload share the low/high bytes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lo_r <= CAM_ZERO8;
            hi_r <= CAM_ZERO8;
        end else if (cap_ev && cap_mode) begin
            lo_r <= cfg.cnt[7:0];
            hi_r <= cfg.cnt[15:8];
        end else begin
            if (wr_lo) begin
                lo_r <= wdata;
            end else if (pwm_mode && cfg.tick && cfg.cnt[7:0] == CAM_BYTE_MAX) begin
                lo_r <= hi_r;
            end
            if (wr_hi) begin
                hi_r <= wdata;
            end
        end
    end

    // toggling output flips on each match while toggle on match is set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_r <= 1'b0;
        end else if (match && cfg.mode[CAM_B_TOG]) begin
            tog_r <= ~tog_r;
        end
    end

    // pwm level registered so the pin never glitches on a compare
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_r <= 1'b0;
        end else begin
            pwm_r <= (cfg.cnt[7:0] >= lo_r);
        end
    end

    assign cap_lo    = lo_r;
    assign cap_hi    = hi_r;
    assign pin_out   = pwm_mode ? pwm_r : tog_r;
    // pin driven only in pwm or toggle output modes; otherwise an input
    assign pin_drive = pwm_mode | (cfg.mode[CAM_B_TOG] & cfg.mode[CAM_B_CMP]
                                   & cfg.mode[CAM_B_MAT]);
endmodule : cam_module

// ==== test/cam_pin_model.sv ====
// pin-side partner: the far end of each module pin
`timescale 1ns/10ps
module cam_pin_model
    import cam_pkg::*;
(
    input  wire logic [CAM_NMOD-1:0] pin_out,
    input  wire logic [CAM_NMOD-1:0] pin_oe_n,
    input  wire logic [CAM_NMOD-1:0] ext_level,
    output logic      [CAM_NMOD-1:0] pin_in
);
    // a driven pin reads back its own level, so the edge logic sees the real wire
    always_comb begin
        for (int i = 0; i < CAM_NMOD; i++) begin
            pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
        end
    end
endmodule : cam_pin_model

// ==== test/cam_properties.sv ====
// checker: port-level timing relations of the counter array
`timescale 1ns/10ps
module cam_checker
    import cam_pkg::*;
(
    input wire logic                CLOCK,
    input wire logic                RST_N,
    input wire logic                COUNT_TICK,
    input wire logic [3:0]          ADDR,
    input wire logic                ADDR_HI,
    input wire logic                WR,
    input wire logic                RD,
    input wire logic [7:0]          RDATA,
    input wire logic [CAM_NMOD-1:0] PIN_OUT,
    input wire logic [CAM_NMOD-1:0] PIN_OE_N,
    input wire logic                IRQ,
    input wire logic                WDOG_RESET
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // a read aimed at one of the five mode registers
    sequence s_mode_read;
        RD && ({ADDR_HI, ADDR} inside {[5'h04:5'h08]});
    endsequence
    // software or a counter tick within the last two cycles; registered paths lag by one
    sequence s_cause;
        $past(WR) || $past(WR, 2) || $past(COUNT_TICK) || $past(COUNT_TICK, 2);
    endsequence
    AST_MODE_BIT7: assert property (s_mode_read |=> !RDATA[7])
        else $error("mode register read shows reserved bit set");
    AST_RESET_QUIET: assert property ($rose(RST_N) |-> PIN_OE_N == 5'h1f && !IRQ)
        else $error("pins driven or interrupt raised out of reset");
    AST_WDOG_PULSE: assert property (WDOG_RESET |=> !WDOG_RESET)
        else $error("watchdog reset longer than one cycle");
    AST_WDOG_CAUSE: assert property (WDOG_RESET |-> $past(COUNT_TICK))
        else $error("watchdog reset without a counter tick");
    AST_PIN_CAUSE: assert property ($changed(PIN_OUT) |-> s_cause)
        else $error("pin level moved without tick or write");
    AST_IRQ_RISE: assert property ($rose(IRQ) |-> s_cause)
        else $error("interrupt rose without event or write");
    AST_IRQ_FALL: assert property ($fell(IRQ) |-> $past(WR))
        else $error("interrupt fell without software write");
    AST_OE_CAUSE: assert property ($changed(PIN_OE_N) |-> $past(WR) || $past(WR, 2))
        else $error("pin drive changed without mode write");
endmodule : cam_checker

bind cam_top cam_checker u_cam_checker (.CLOCK(CLOCK), .RST_N(RST_N), .COUNT_TICK(COUNT_TICK),
    .ADDR(ADDR), .ADDR_HI(ADDR_HI), .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_OUT(PIN_OUT),
    .PIN_OE_N(PIN_OE_N), .IRQ(IRQ), .WDOG_RESET(WDOG_RESET));

// ==== test/tb.sv ====
// bench: register accesses, pin stimulus and checks for the counter array
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb
    import cam_pkg::*;
;
    logic        CLOCK = 1'b0;
    logic        RST_N = 1'b0;
    logic        COUNT_TICK = 1'b0;
    logic [3:0]  ADDR = 4'h0;
    logic        ADDR_HI = 1'b0;
    logic [7:0]  WDATA = 8'h00;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic [7:0]  RDATA;
    logic [4:0]  PIN_IN, PIN_OUT, PIN_OE_N;
    logic [4:0]  ext = 5'h00;
    logic        IRQ, WDOG_RESET;
    logic        wd_seen = 1'b0;
    logic [15:0] cnt, exp;
    logic [7:0]  cmode [3] = '{8'h21, 8'h11, 8'h31};
    logic [1:0]  cap_on [3] = '{2'b01, 2'b10, 2'b11};
    int          fails = 0;
    int          n_compared = 0;

    always #25 CLOCK = ~CLOCK;

    cam_top dut (.CLOCK(CLOCK), .RST_N(RST_N), .COUNT_TICK(COUNT_TICK), .ADDR(ADDR),
        .ADDR_HI(ADDR_HI), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_IN(PIN_IN),
        .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N), .IRQ(IRQ), .WDOG_RESET(WDOG_RESET));
    cam_pin_model u_pins (.pin_out(PIN_OUT), .pin_oe_n(PIN_OE_N), .ext_level(ext),
        .pin_in(PIN_IN));

    // the watchdog pulse stands one cycle only, so latch it
    always @(posedge CLOCK) if (WDOG_RESET === 1'b1) wd_seen <= 1'b1;

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        {ADDR_HI, ADDR} <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge CLOCK);
        {ADDR_HI, ADDR} <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        @(negedge CLOCK);
        `CHK(RDATA, e)
    endtask : rd
    // one tick; the model count always advances, whether or not the run bit is set
    task automatic tick();
        @(posedge CLOCK);
        COUNT_TICK <= 1'b1;
        @(posedge CLOCK);
        COUNT_TICK <= 1'b0;
        cnt = cnt + 16'h0001;
        repeat (2) @(negedge CLOCK);
    endtask : tick
    task automatic set_cnt(input logic [15:0] v);
        wr(5'h01, v[7:0]);
        wr(5'h02, v[15:8]);
        cnt = v;
        repeat (2) @(negedge CLOCK);
    endtask : set_cnt
    task automatic stop_test();
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test

    initial begin
        #200000;
        fails++;
        stop_test();
    end

    initial begin
        repeat (6) @(posedge CLOCK);
        RST_N <= 1'b1;
        for (int i = 0; i < CAM_NMOD; i++) rd(5'h04 + 5'(i), 8'h00);
        `CHK(PIN_OE_N, 5'h1f)
        wr(5'h1f, 8'h55);
        rd(5'h1f, 8'h00);
        wr(5'h04, 8'hff);
        rd(5'h04, 8'h7f);
        wr(5'h04, 8'h00);
        wr(5'h00, 8'h40);
        set_cnt(16'h1234);
        // capture: each edge setting on its own module, pin goes up then down
        for (int m = 0; m < 3; m++) begin
            wr(5'h04 + 5'(m), cmode[m]);
            wr(5'h09 + 5'(m), 8'h00);
            wr(5'h0e + 5'(m), 8'h00);
            exp = 16'h0000;
            for (int s = 0; s < 2; s++) begin
                @(posedge CLOCK);
                ext[m] <= (s == 0);
                if (cap_on[m][s]) exp = cnt;
                tick();
                rd(5'h09 + 5'(m), exp[7:0]);
                rd(5'h0e + 5'(m), exp[15:8]);
            end
            rd(5'h00, 8'h40 | (8'h01 << m));
            `CHK(IRQ, 1'b1)
            wr(5'h00, 8'h40);
            @(negedge CLOCK);
            `CHK(IRQ, 1'b0)
        end
        // compare match on module 3: pin toggles, flag and interrupt follow
        exp = cnt + 16'h0002;
        wr(5'h0c, exp[7:0]);
        wr(5'h11, exp[15:8]);
        wr(5'h07, 8'h4d);
        repeat (2) @(negedge CLOCK);
        `CHK(PIN_OE_N[3], 1'b0)
        tick();
        tick();
        `CHK(PIN_OUT[3], 1'b0)
        tick();
        `CHK(PIN_OUT[3], 1'b1)
        `CHK(IRQ, 1'b1)
        rd(5'h00, 8'h48);
        `CHK(wd_seen, 1'b0)
        wr(5'h00, 8'h40);
        wr(5'h07, 8'h00);
        // pwm on module 4: low below duty, high at or above, reload at rollover
        wr(5'h0d, 8'h80);
        wr(5'h12, 8'h40);
        wr(5'h08, 8'h42);
        set_cnt(16'h007f);
        `CHK(PIN_OUT[4], 1'b0)
        `CHK(PIN_OE_N[4], 1'b0)
        tick();
        `CHK(PIN_OUT[4], 1'b1)
        set_cnt(16'h00ff);
        tick();
        rd(5'h0d, 8'h40);
        `CHK(PIN_OUT[4], 1'b0)
        // watchdog on module 4: a compare match gives one reset pulse
        wr(5'h08, 8'h48);
        exp = cnt + 16'h0001;
        wr(5'h0d, exp[7:0]);
        wr(5'h12, exp[15:8]);
        wr(5'h03, 8'h01);
        tick();
        tick();
        `CHK(wd_seen, 1'b1)
        // run bit cleared: a tick no longer advances the shared counter
        wr(5'h00, 8'h00);
        tick();
        cnt = cnt - 16'h0001;
        rd(5'h01, cnt[7:0]);
        rd(5'h02, cnt[15:8]);
        stop_test();
    end
endmodule : tb
